// ---- src/lqm_defines.svh ----
// Offsets, field positions, reset values and encodings of the link quality monitor.
//
// Overview of operation
// - Enable bit 15 RW, runs only with 100Mb link
// - Threshold at range limit never reports violation
// - Frequency control crossings set bits 9 and 8
// - Frequency offset crossings set bits 7 and 6
// - Baseline wander crossings set bits 5 and 4
// - Gain crossings set bits 3 and 2
// - Equalizer coefficient crossings set bits 1, 0
// - Flags read-only, reset 0, cleared by read
// - Interrupt raised only where its mask enables it
// - Control read clears flags and re-arms interrupt
// - Bits 14 to 10 ignore writes, read 0
// - Optional automatic 100Mb link reset on warning
// - Three-bit selector picks the monitored parameter
// - Threshold select: 0 low, 1 high
`ifndef LQM_DEFINES_SVH
`define LQM_DEFINES_SVH

// ****************************************************************
// Register indices; byte address is four times the index.
// ****************************************************************
`define LQM_IDX_CTRL 5'h1d
`define LQM_IDX_THR_DATA 5'h1e
`define LQM_IDX_IRQ_MASK 5'h12
`define LQM_IDX_AUTO_RST 5'h1f

// ****************************************************************
// Field positions.
// ****************************************************************
`define LQM_BIT_ENABLE 15
`define LQM_NUM_FLAGS 10
`define LQM_NUM_PARAMS 5
`define LQM_BIT_SAMPLE 13
`define LQM_BIT_WR_THR 12
`define LQM_SEL_HI 11
`define LQM_SEL_LO 9
`define LQM_BIT_THR_SEL 8
`define LQM_PARAM_W 8

// ****************************************************************
// Reset values.
// ****************************************************************
`define LQM_RST_FLAGS 10'h000
`define LQM_RST_MASK 10'h000
`define LQM_RST_HIGH_THR 8'hff
`define LQM_RST_LOW_THR 8'h00

`endif

// ---- src/lqm_pkg.sv ----
// Types shared by the link quality monitor modules.
package lqm_pkg;
    // One bit per warning flag, bit order as in the control register.
    typedef logic [9:0] lqm_flags_t;
    // One value of a monitored receiver parameter.
    typedef logic [7:0] lqm_param_t;
    // Monitored parameter selector codes.
    typedef logic [2:0] lqm_sel_t;
endpackage

// ---- src/lqm_thr_bank.sv ----
// Storage of the high and low thresholds of every monitored parameter.
`timescale 1ns/1ps
`default_nettype none
`include "lqm_defines.svh"
module lqm_thr_bank #(
    parameter int NUM = `LQM_NUM_PARAMS,
    parameter int W = `LQM_PARAM_W
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port.
    input wire logic wr_i,
    input wire logic [2:0] wr_sel_i,
    input wire logic wr_high_i,
    input wire logic [W-1:0] wr_data_i,
    // All thresholds, parameter n at [n*W +: W].
    output logic [NUM*W-1:0] high_o,
    output logic [NUM*W-1:0] low_o
);
    // ****************************************************************
    // Threshold arrays.
    // ****************************************************************
    logic [W-1:0] high_thr [NUM];
    logic [W-1:0] low_thr [NUM];

    genvar g;
    generate
        for (g = 0; g < NUM; g++) begin : g_thr
            // Reset to range limits so no comparison fires until programmed.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    high_thr[g] <= W'(`LQM_RST_HIGH_THR);
                    low_thr[g] <= W'(`LQM_RST_LOW_THR);
                end else if (wr_i && wr_sel_i == 3'(g)) begin
                    if (wr_high_i) begin
                        high_thr[g] <= wr_data_i;
                    end else begin
                        low_thr[g] <= wr_data_i;
                    end
                end
            end
            assign high_o[g*W +: W] = high_thr[g];
            assign low_o[g*W +: W] = low_thr[g];
        end
    endgenerate
endmodule
`default_nettype wire

// ---- src/lqm_compare.sv ----
// Threshold comparison of every monitored parameter.
`timescale 1ns/1ps
`default_nettype none
`include "lqm_defines.svh"
module lqm_compare #(
    parameter int NUM = `LQM_NUM_PARAMS,
    parameter int W = `LQM_PARAM_W
) (
    // Monitor qualification and samples.
    input wire logic active_i,
    input wire logic [NUM*W-1:0] param_i,
    input wire logic [NUM*W-1:0] high_i,
    input wire logic [NUM*W-1:0] low_i,
    // Violations, bit 2n+1 high and 2n low of parameter n.
    output logic [2*NUM-1:0] hit_o
);
    localparam logic [W-1:0] MAXV = '1;
    localparam logic [W-1:0] MINV = '0;

    genvar g;
    generate
        for (g = 0; g < NUM; g++) begin : g_cmp
            wire logic [W-1:0] p = param_i[g*W +: W];
            wire logic [W-1:0] h = high_i[g*W +: W];
            wire logic [W-1:0] l = low_i[g*W +: W];
            // A threshold at its range limit is switched off explicitly.
            assign hit_o[2*g+1] = active_i && h != MAXV && p > h;
            assign hit_o[2*g] = active_i && l != MINV && p < l;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- src/lqm_monitor.sv ----
// Link quality monitor control, warning flags and Wishbone register slave.
`timescale 1ns/1ps
`default_nettype none
`include "lqm_defines.svh"
module lqm_monitor #(
    parameter int W = `LQM_PARAM_W
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Receiver parameters, same clock domain.
    input wire logic link_100_valid_i,
    input wire logic [W-1:0] equalizer_coeff_param_i,
    input wire logic [W-1:0] digital_gain_param_i,
    input wire logic [W-1:0] baseline_wander_param_i,
    input wire logic [W-1:0] freq_offset_param_i,
    input wire logic [W-1:0] freq_control_param_i,
    // Interrupt and link reset request.
    output logic irq_o,
    output logic link_reset_o
);
    localparam int NUM = `LQM_NUM_PARAMS;

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    // A request is taken in the cycle before ack rises.
    wire logic take = cyc_i && stb_i && !ack_o;
    wire logic [5:0] idx = adr_i[7:2];
    wire logic hit_ctrl = idx == 6'(`LQM_IDX_CTRL);
    wire logic hit_thr = idx == 6'(`LQM_IDX_THR_DATA);
    wire logic hit_mask = idx == 6'(`LQM_IDX_IRQ_MASK);
    wire logic hit_auto = idx == 6'(`LQM_IDX_AUTO_RST);
    // Byte lanes 0 and 1 carry the 16-bit registers.
    wire logic wr_lo = take && we_i && sel_i[0];
    wire logic wr_hi = take && we_i && sel_i[1];
    wire logic rd_take = take && !we_i;

    // ****************************************************************
    // Register state.
    // ****************************************************************
    logic monitor_enable; // Monitor enable bit.
    lqm_pkg::lqm_flags_t flags; // Sticky warning flags.
    lqm_pkg::lqm_flags_t irq_mask; // Interrupt enables.
    logic auto_reset_en; // Automatic link reset option.
    logic sample_param; // Read back sampled parameter.
    lqm_pkg::lqm_sel_t parameter_selector; // Parameter selector.
    logic threshold_selector; // 0 low, 1 high.
    lqm_pkg::lqm_param_t sampled; // Last sampled parameter.

    // ****************************************************************
    // Threshold storage and comparison.
    // ****************************************************************
    wire logic [NUM*W-1:0] params = {freq_control_param_i, freq_offset_param_i,
        baseline_wander_param_i, digital_gain_param_i, equalizer_coeff_param_i};
    wire logic [NUM*W-1:0] high_thr;
    wire logic [NUM*W-1:0] low_thr;
    wire logic [2*NUM-1:0] hits;
    // A threshold write is the write strobe bit in the upper lane.
    wire logic thr_wr = wr_hi && hit_thr && dat_i[`LQM_BIT_WR_THR];
    // Selector as it stands after this write, so one write suffices.
    wire logic [2:0] thr_sel = wr_hi && hit_thr ?
        dat_i[`LQM_SEL_HI:`LQM_SEL_LO] : parameter_selector;
    // Bit 8 travels in byte lane 1, beside the parameter selector.
    wire logic thr_hi = wr_hi && hit_thr ?
        dat_i[`LQM_BIT_THR_SEL] : threshold_selector;
    // Monitoring runs only with enable set and a 100Mb link up.
    wire logic active = monitor_enable && link_100_valid_i;

    lqm_thr_bank #(
        .NUM(NUM),
        .W(W)
    ) u_bank (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(thr_wr),
        .wr_sel_i(thr_sel),
        .wr_high_i(thr_hi),
        .wr_data_i(dat_i[W-1:0]),
        .high_o(high_thr),
        .low_o(low_thr)
    );

    lqm_compare #(
        .NUM(NUM),
        .W(W)
    ) u_cmp (
        .active_i(active),
        .param_i(params),
        .high_i(high_thr),
        .low_i(low_thr),
        .hit_o(hits)
    );

    // ****************************************************************
    // Flag update.
    // ****************************************************************
    // Hit bit 2n+1/2n already matches flag layout: 9,8 frequency control,
    // 7,6 frequency offset, 5,4 baseline wander, 3,2 gain, 1,0 equalizer.
    wire lqm_pkg::lqm_flags_t new_hits = hits;
    // A read of the control register clears all flags.
    wire logic clr_flags = rd_take && hit_ctrl;
    // New hits win over the clear so no event is lost.
    wire lqm_pkg::lqm_flags_t next_flags =
        (clr_flags ? `LQM_RST_FLAGS : flags) | new_hits;
    // A flag rising from clear to set is a fresh warning.
    wire logic fresh = |(new_hits & ~flags);
    // Selected threshold for read back, and the selected parameter, left unused.
    wire logic [W-1:0] sel_thr = threshold_selector ?
        high_thr[parameter_selector*W +: W] : low_thr[parameter_selector*W +: W];
    wire logic [W-1:0] sel_param = params[parameter_selector*W +: W];

    // Flags set from the comparators and clear on a control read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= `LQM_RST_FLAGS;
        end else begin
            flags <= next_flags;
        end
    end

    // ****************************************************************
    // Software writable controls.
    // ****************************************************************
    // Control, mask and option writes; reserved bits are never stored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            monitor_enable <= 1'b0;
            irq_mask <= `LQM_RST_MASK;
            auto_reset_en <= 1'b0;
        end else begin
            if (wr_hi && hit_ctrl) begin
                monitor_enable <= dat_i[`LQM_BIT_ENABLE];
            end
            if (wr_lo && hit_mask) begin
                irq_mask[7:0] <= dat_i[7:0];
            end
            if (wr_hi && hit_mask) begin
                irq_mask[9:8] <= dat_i[9:8];
            end
            if (wr_lo && hit_auto) begin
                auto_reset_en <= dat_i[0];
            end
        end
    end

    // Threshold data register fields and parameter sampling.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_param <= 1'b0;
            parameter_selector <= 3'h0;
            threshold_selector <= 1'b0;
            sampled <= 8'h00;
        end else begin
            if (wr_hi && hit_thr) begin
                sample_param <= dat_i[`LQM_BIT_SAMPLE];
                parameter_selector <= dat_i[`LQM_SEL_HI:`LQM_SEL_LO];
            end
            if (wr_hi && hit_thr) begin
                threshold_selector <= dat_i[`LQM_BIT_THR_SEL];
            end
            // Setting the sample bit captures the selected parameter.
            if (wr_hi && hit_thr && dat_i[`LQM_BIT_SAMPLE]) begin
                sampled <= params[thr_sel*W +: W];
            end
        end
    end

    // ****************************************************************
    // Read data mux.
    // ****************************************************************
    // Reserved bits and unmapped indices read as zero.
    wire logic [15:0] rd_ctrl = {monitor_enable, 5'h00, flags};
    wire logic [15:0] rd_thr = {2'h0, sample_param, 1'b0, parameter_selector,
        threshold_selector, sample_param ? sampled : sel_thr};
    wire logic [15:0] rd_mux =
        hit_ctrl ? rd_ctrl :
        hit_thr ? rd_thr :
        hit_mask ? {6'h00, irq_mask} :
        hit_auto ? {15'h0000, auto_reset_en} : 16'h0000;

    // Classic single cycle: one wait state, ack for one cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= take;
            dat_o <= rd_take ? {16'h0000, rd_mux} : 32'h00000000;
        end
    end

    // ****************************************************************
    // Interrupt and automatic link reset.
    // ****************************************************************
    // Level interrupt while any enabled flag stands; the clearing read
    // drops it and re-arms it for the next violation.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            link_reset_o <= 1'b0;
        end else begin
            irq_o <= |(next_flags & irq_mask);
            link_reset_o <= auto_reset_en && fresh;
        end
    end

    // Unused bus inputs are the upper data lanes of the 16-bit registers.
    wire logic unused_ok = &{1'b0, dat_i[31:16], sel_i[3:2], sel_param};
endmodule
`default_nettype wire

// ---- verif/lqm_monitor_properties.sv ----
// Concurrent checks on the ports of the link quality monitor.
`timescale 1ns/1ps
`default_nettype none
module lqm_monitor_checker #(
    parameter int W = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Link state and outputs.
    input wire logic link_100_valid_i,
    input wire logic irq_o,
    input wire logic link_reset_o
);
    // ****************************************************************
    // Sequences and properties.
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A request that the slave takes at this edge.
    sequence take_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    // A taken read of the control register.
    sequence ctrl_read_s;
        take_s ##0 (!we_i && adr_i[7:2] == 6'h1d);
    endsequence
    ack_next_a: assert property (take_s |=> ack_o)
        else $error("Taken request was not acknowledged next cycle.");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("Acknowledge stayed high two cycles.");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("Acknowledge without a request.");
    dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("Read data not zero outside acknowledge.");
    ctrl_rsvd_a: assert property (ctrl_read_s |=> {dat_o[31:16], dat_o[14:10]} == 21'h0)
        else $error("Reserved control bits read nonzero.");
    irq_rise_a: assert property ($rose(irq_o) |->
        $past(link_100_valid_i) || $past(cyc_i && stb_i && we_i))
        else $error("Interrupt rose without link or mask write.");
    irq_fall_a: assert property ($fell(irq_o) |->
        (cyc_i && stb_i) || $past(cyc_i && stb_i))
        else $error("Interrupt fell without a register access.");
    lreset_link_a: assert property (link_reset_o |->
        $past(link_100_valid_i) || $past(link_100_valid_i, 2))
        else $error("Link reset request without a valid link.");
endmodule
bind lqm_monitor lqm_monitor_checker #(.W(W)) lqm_monitor_checker_i (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
    .ack_o(ack_o), .link_100_valid_i(link_100_valid_i), .irq_o(irq_o),
    .link_reset_o(link_reset_o));
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking testbench of the link quality monitor register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ****************************************************************
    // Signals, counters and the table of ordinary cases.
    // ****************************************************************
    typedef struct {logic [2:0] sel; logic hi; logic [7:0] thr; logic [7:0] val;
        logic [9:0] flags;} lqm_row_t;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, link_reset_o, link_100_valid_i;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    lqm_pkg::lqm_param_t p [5]; // Parameter samples, indexed by selector code.
    int n_fail, n_compared, n_pulse, n_hit;
    // Selector, threshold side, threshold, sample, expected flags.
    lqm_row_t rows [14] = '{
        '{3'd0, 1'b1, 8'h80, 8'h81, 10'h002}, '{3'd0, 1'b0, 8'h40, 8'h3f, 10'h001},
        '{3'd1, 1'b1, 8'h90, 8'hfe, 10'h008}, '{3'd1, 1'b0, 8'h70, 8'h00, 10'h004},
        '{3'd2, 1'b1, 8'ha0, 8'ha1, 10'h020}, '{3'd2, 1'b0, 8'h10, 8'h0f, 10'h010},
        '{3'd3, 1'b1, 8'hc0, 8'hc1, 10'h080}, '{3'd3, 1'b0, 8'h01, 8'h00, 10'h040},
        '{3'd4, 1'b1, 8'hfe, 8'hff, 10'h200}, '{3'd4, 1'b0, 8'h7f, 8'h7e, 10'h100},
        '{3'd2, 1'b1, 8'h90, 8'h90, 10'h000}, '{3'd3, 1'b0, 8'h50, 8'h50, 10'h000},
        '{3'd1, 1'b1, 8'hff, 8'hff, 10'h000}, '{3'd1, 1'b0, 8'h00, 8'h00, 10'h000}};
    lqm_monitor #(.W(8)) lqm_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .link_100_valid_i(link_100_valid_i),
        .equalizer_coeff_param_i(p[0]), .digital_gain_param_i(p[1]),
        .baseline_wander_param_i(p[2]), .freq_offset_param_i(p[3]),
        .freq_control_param_i(p[4]), .irq_o(irq_o), .link_reset_o(link_reset_o));
    // The clock toggles every 50 ns, half of its 100 ns period.
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Link reset pulses are counted for the comparison after the ordinary cases.
    always @(posedge clk_i) begin
        if (link_reset_o === 1'b1) begin
            n_pulse++;
        end
    end
    // ****************************************************************
    // Tasks.
    // ****************************************************************
    // Counts one comparison and reports a mismatch.
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One classic Wishbone cycle; read data lands in rd.
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Programs one threshold, pulses the sample for two cycles, restores the limit.
    task automatic hit(input lqm_row_t r);
        wb(1'b1, 8'h78, {4'b0001, r.sel, r.hi, r.thr});
        p[r.sel] <= r.val;
        repeat (2) @(posedge clk_i);
        p[r.sel] <= 8'h80;
        @(posedge clk_i);
        wb(1'b1, 8'h78, {4'b0001, r.sel, r.hi, r.hi ? 8'hff : 8'h00});
    endtask
    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run time.
    initial begin
        #2000000;
        n_fail++;
        give_verdict();
    end
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        {rst_i, link_100_valid_i} = 2'b11;
        {cyc_i, stb_i, we_i} = 3'b000;
        {adr_i, sel_i, dat_i} = '0;
        sel_i = 4'hf;
        foreach (p[k]) p[k] = 8'h80;
        {n_fail, n_compared, n_pulse, n_hit} = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h74, 16'h0000);
        check("ctrl reset", 32'h0, rd);
        wb(1'b1, 8'h74, 16'hffff);
        wb(1'b0, 8'h74, 16'h0000);
        check("ctrl write ones", 32'h8000, rd);
        wb(1'b0, 8'h04, 16'h0000);
        check("unmapped read", 32'h0, rd);
        wb(1'b1, 8'h48, 16'h03ff);
        wb(1'b1, 8'h7c, 16'h0001);
        // Ordinary cases: each crossing sets its own flag and raises the interrupt.
        foreach (rows[i]) begin
            hit(rows[i]);
            n_hit += (rows[i].flags != 10'h000);
            check("irq after event", {31'h0, rows[i].flags != 0}, {31'h0, irq_o});
            wb(1'b0, 8'h74, 16'h0000);
            check("flags", {16'h0, 6'h20, rows[i].flags}, rd);
            check("irq after read", 32'h0, {31'h0, irq_o});
        end
        wb(1'b0, 8'h74, 16'h0000);
        check("flags after clear", 32'h8000, rd);
        check("link reset pulses", n_hit, n_pulse);
        // A violation that persists through the clearing read keeps its flag.
        wb(1'b1, 8'h78, 16'h1180);
        p[0] <= 8'hc0;
        wb(1'b0, 8'h74, 16'h0000);
        wb(1'b0, 8'h74, 16'h0000);
        check("flag kept on read", 32'h8002, rd);
        p[0] <= 8'h80;
        wb(1'b1, 8'h78, 16'h11ff);
        wb(1'b0, 8'h74, 16'h0000);
        // A masked event sets its flag but no interrupt.
        wb(1'b1, 8'h48, 16'h0000);
        hit(rows[0]);
        check("masked irq", 32'h0, {31'h0, irq_o});
        wb(1'b0, 8'h74, 16'h0000);
        check("masked flag", 32'h8002, rd);
        // No flags without the enable, nor without a valid link.
        wb(1'b1, 8'h74, 16'h0000);
        hit(rows[0]);
        wb(1'b0, 8'h74, 16'h0000);
        check("disabled flags", 32'h0, rd);
        wb(1'b1, 8'h74, 16'h8000);
        link_100_valid_i <= 1'b0;
        hit(rows[2]);
        link_100_valid_i <= 1'b1;
        wb(1'b0, 8'h74, 16'h0000);
        check("no link flags", 32'h8000, rd);
        // A reset in mid-run drops a standing flag, the interrupt and the mask.
        wb(1'b1, 8'h48, 16'h03ff);
        hit(rows[0]);
        check("irq before reset", 32'h1, {31'h0, irq_o});
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("irq after reset", 32'h0, {31'h0, irq_o});
        wb(1'b0, 8'h74, 16'h0000);
        check("ctrl after reset", 32'h0, rd);
        wb(1'b0, 8'h48, 16'h0000);
        check("mask after reset", 32'h0, rd);
        give_verdict();
    end
endmodule
`default_nettype wire
